// ---- hw/vit_top.sv ----
// Vectored interrupt controller with its free-running microsecond timer.
// Assumes a CPU that takes the vector on irq and pulses int_ack once.
`timescale 1ns/1ps
`default_nettype none
module vit_top #(
  parameter int unsigned TICK_DIV = vit_pkg::TICK_CYCLES
) (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  input wire logic usb_bus_reset,
  input wire logic [vit_pkg::NUM_EP-1:0] ep_event,
  input wire logic serial_event,
  input wire logic [vit_pkg::SINK_W-1:0] sink_pin,
  input wire logic [vit_pkg::GP_PORTS*vit_pkg::GP_PORT_W-1:0] gp_pin,
  input wire logic int_ack,
  output logic irq,
  output logic [vit_pkg::VEC_W-1:0] irq_vec
);

  // ==========================================================
  // Local sizes
  // ==========================================================
  localparam int unsigned GP_W = vit_pkg::GP_PORTS * vit_pkg::GP_PORT_W;
  localparam int unsigned NS = vit_pkg::NUM_SRC;
  localparam int unsigned DIV_W = $clog2(TICK_DIV + 1);

  // ==========================================================
  // Reset release
  // ==========================================================
  logic rst_s1_q;     // First reset stage
  logic rst_sync_n;   // Released copy used everywhere else

  // Assert at once, release after two edges
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      rst_s1_q <= 1'b0;
      rst_sync_n <= 1'b0;
    end else begin
      rst_s1_q <= 1'b1;
      rst_sync_n <= rst_s1_q;
    end
  end

  // ==========================================================
  // Register port decode
  // ==========================================================
  logic rd_tmr_lo;    // Low timer byte read
  logic rd_stat_lo;   // Low status read
  logic rd_stat_hi;   // High status read

  assign rd_tmr_lo = reg_rd && (reg_addr == vit_pkg::REG_TMR_LO);
  assign rd_stat_lo = reg_rd && (reg_addr == vit_pkg::REG_STAT_LO);
  assign rd_stat_hi = reg_rd && (reg_addr == vit_pkg::REG_STAT_HI);

  // ==========================================================
  // Microsecond tick and counter
  // ==========================================================
  logic [DIV_W-1:0] div_q;        // Clock divider
  logic tick_q;                   // One-cycle 1 MHz enable
  logic [vit_pkg::TMR_W-1:0] tmr_q; // Free-running count
  logic [3:0] hold_q;             // Upper bits caught on low read
  logic tap_fast_q;               // Previous fast tap level
  logic tap_slow_q;               // Previous slow tap level
  logic tap_fast_rise;            // Fast tap edge
  logic tap_slow_rise;            // Slow tap edge

  // Divider makes one enable pulse per microsecond
  always_ff @(posedge mclk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      div_q <= '0;
      tick_q <= 1'b0;
    end else if (div_q == DIV_W'(TICK_DIV - 1)) begin
      div_q <= '0;
      tick_q <= 1'b1;
    end else begin
      div_q <= div_q + DIV_W'(1);
      tick_q <= 1'b0;
    end
  end

  // Up-counter wraps freely; no load from software
  always_ff @(posedge mclk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      tmr_q <= vit_pkg::TMR_RESET;
    end else if (tick_q) begin
      tmr_q <= tmr_q + vit_pkg::TMR_W'(1);
    end
  end

  // Holding register avoids a carry tearing a two-byte read
  always_ff @(posedge mclk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      hold_q <= 4'h0;
    end else if (rd_tmr_lo) begin
      hold_q <= tmr_q[11:8];
    end
  end

  // Tap level history for edge detection
  always_ff @(posedge mclk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      tap_fast_q <= 1'b0;
      tap_slow_q <= 1'b0;
    end else begin
      tap_fast_q <= tmr_q[vit_pkg::TAP_FAST];
      tap_slow_q <= tmr_q[vit_pkg::TAP_SLOW];
    end
  end

  // Only the low-to-high change counts
  assign tap_fast_rise = tmr_q[vit_pkg::TAP_FAST] & ~tap_fast_q;
  assign tap_slow_rise = tmr_q[vit_pkg::TAP_SLOW] & ~tap_slow_q;

  // ==========================================================
  // Pin transition detectors
  // ==========================================================
  logic [vit_pkg::SINK_W-1:0] sink_rise; // Sink pin rising pulses
  logic [vit_pkg::SINK_W-1:0] sink_fall; // Sink pin falling pulses
  logic [GP_W-1:0] gp_rise;              // Port pin rising pulses
  logic [GP_W-1:0] gp_fall;              // Port pin falling pulses

  // Sink port lanes
  vit_pin_edge #(
    .W(vit_pkg::SINK_W)
  ) u_sink_edge (
    .clk(mclk),
    .rst_sync_n(rst_sync_n),
    .pin(sink_pin),
    .rise(sink_rise),
    .fall(sink_fall)
  );

  // General-purpose port lanes
  vit_pin_edge #(
    .W(GP_W)
  ) u_gp_edge (
    .clk(mclk),
    .rst_sync_n(rst_sync_n),
    .pin(gp_pin),
    .rise(gp_rise),
    .fall(gp_fall)
  );

  // ==========================================================
  // Configuration registers
  // ==========================================================
  logic [NS-1:0] en_q;                       // Source enables, also the irq mask
  logic [vit_pkg::SINK_W-1:0] sink_en_q;     // Sink pin mask
  logic [vit_pkg::SINK_W-1:0] sink_pol_q;    // Sink pin polarity
  logic [GP_W-1:0] gp_en_q;                  // Port pin masks
  logic [vit_pkg::GP_PORTS-1:0] gp_cfg_q;    // Port polarity

  // Source enable bytes
  always_ff @(posedge mclk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      en_q <= vit_pkg::EN_RESET;
    end else if (reg_wr) begin
      if (reg_addr == vit_pkg::REG_EN_LO) begin
        en_q[7:0] <= reg_wdata;
      end else if (reg_addr == vit_pkg::REG_EN_HI) begin
        en_q[NS-1:8] <= reg_wdata[NS-9:0];
      end
    end
  end

  // Sink mask and per-pin polarity
  always_ff @(posedge mclk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      sink_en_q <= vit_pkg::BYTE_RESET;
      sink_pol_q <= vit_pkg::BYTE_RESET;
    end else if (reg_wr) begin
      if (reg_addr == vit_pkg::REG_SINK_EN) begin
        sink_en_q <= reg_wdata;
      end else if (reg_addr == vit_pkg::REG_SINK_POL) begin
        sink_pol_q <= reg_wdata;
      end
    end
  end

  // Port masks, one byte per port, and per-port polarity
  always_ff @(posedge mclk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      gp_en_q <= '0;
      gp_cfg_q <= vit_pkg::GP_CFG_RESET;
    end else if (reg_wr) begin
      if (reg_addr == vit_pkg::REG_GP_CFG) begin
        gp_cfg_q <= reg_wdata[vit_pkg::GP_PORTS-1:0];
      end else begin
        for (int p = 0; p < vit_pkg::GP_PORTS; p++) begin
          if (reg_addr == vit_pkg::REG_GP_EN0 + 8'(p)) begin
            gp_en_q[p*vit_pkg::GP_PORT_W +: vit_pkg::GP_PORT_W] <= reg_wdata;
          end
        end
      end
    end
  end

  // ==========================================================
  // Source events
  // ==========================================================
  logic [GP_W-1:0] gp_pol;  // Port polarity spread to every pin
  logic sink_hit;           // Any unmasked sink pin saw its chosen edge
  logic gp_hit;             // Any unmasked port pin saw its port's edge
  logic [NS-1:0] src_evt;   // Raw events in vector order
  logic [NS-1:0] set;       // Events of enabled sources

  // Each pin inherits its port's polarity
  always_comb begin
    for (int b = 0; b < GP_W; b++) begin
      gp_pol[b] = gp_cfg_q[b / vit_pkg::GP_PORT_W];
    end
  end

  // Polarity 1 picks rising, 0 picks falling
  assign sink_hit = |(sink_en_q & ((sink_rise & sink_pol_q) |
                                   (sink_fall & ~sink_pol_q)));
  assign gp_hit = |(gp_en_q & ((gp_rise & gp_pol) | (gp_fall & ~gp_pol)));

  // Gather the eleven sources
  always_comb begin
    src_evt = '0;
    src_evt[vit_pkg::SRC_BUS_RESET] = usb_bus_reset;
    src_evt[vit_pkg::SRC_TMR_FAST] = tap_fast_rise;
    src_evt[vit_pkg::SRC_TMR_SLOW] = tap_slow_rise;
    src_evt[vit_pkg::SRC_EP0 +: vit_pkg::NUM_EP] = ep_event;
    src_evt[vit_pkg::SRC_SINK] = sink_hit;
    src_evt[vit_pkg::SRC_GPIO] = gp_hit;
    src_evt[vit_pkg::SRC_SERIAL] = serial_event;
  end

  // A disabled source leaves no trace
  assign set = src_evt & en_q;

  // ==========================================================
  // Pending flags
  // ==========================================================
  logic [NS-1:0] pend_q;    // Sticky pending flags
  logic [NS-1:0] clr;       // Clears from dispatch and status reads

  // Dispatch clears the vector on ack; a read clears its byte
  always_comb begin
    clr = '0;
    if (int_ack && irq) begin
      clr[irq_vec] = 1'b1;
    end
    if (rd_stat_lo) begin
      clr[7:0] = 8'hff;
    end
    if (rd_stat_hi) begin
      clr[NS-1:8] = '1;
    end
  end

  // A new event wins over a clear in the same cycle
  always_ff @(posedge mclk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      pend_q <= vit_pkg::PEND_RESET;
    end else begin
      pend_q <= (pend_q & ~clr) | set;
    end
  end

  // ==========================================================
  // Vector selection
  // ==========================================================
  logic [NS-1:0] live;                  // Pending and unmasked
  logic [vit_pkg::VEC_W-1:0] vec_d;     // Lowest live index

  // Fixed priority: lowest source number first
  always_comb begin
    live = pend_q & en_q;
    vec_d = vit_pkg::VEC_RESET;
    for (int s = NS - 1; s >= 0; s--) begin
      if (live[s]) begin
        vec_d = vit_pkg::VEC_W'(s);
      end
    end
  end

  // Registered request and vector; one cycle behind pending
  always_ff @(posedge mclk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      irq <= 1'b0;
      irq_vec <= vit_pkg::VEC_RESET;
    end else begin
      irq <= |live;
      irq_vec <= vec_d;
    end
  end

  // ==========================================================
  // Read data
  // ==========================================================
  // Data stand only in the cycle after the strobe
  always_ff @(posedge mclk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      reg_rdata <= vit_pkg::BYTE_RESET;
    end else if (!reg_rd) begin
      reg_rdata <= vit_pkg::BYTE_RESET;
    end else if (reg_addr == vit_pkg::REG_TMR_LO) begin
      reg_rdata <= tmr_q[7:0];
    end else if (reg_addr == vit_pkg::REG_TMR_HI) begin
      reg_rdata <= {4'h0, hold_q};
    end else if (reg_addr == vit_pkg::REG_EN_LO) begin
      reg_rdata <= en_q[7:0];
    end else if (reg_addr == vit_pkg::REG_EN_HI) begin
      reg_rdata <= {5'h00, en_q[NS-1:8]};
    end else if (reg_addr == vit_pkg::REG_STAT_LO) begin
      reg_rdata <= pend_q[7:0];
    end else if (reg_addr == vit_pkg::REG_STAT_HI) begin
      reg_rdata <= {5'h00, pend_q[NS-1:8]};
    end else if (reg_addr == vit_pkg::REG_SINK_EN) begin
      reg_rdata <= sink_en_q;
    end else if (reg_addr == vit_pkg::REG_SINK_POL) begin
      reg_rdata <= sink_pol_q;
    end else if (reg_addr == vit_pkg::REG_GP_CFG) begin
      reg_rdata <= {4'h0, gp_cfg_q};
    end else if (reg_addr >= vit_pkg::REG_GP_EN0 &&
                 reg_addr < vit_pkg::REG_GP_EN0 + 8'(vit_pkg::GP_PORTS)) begin
      // Port masks read back for convenience
      reg_rdata <= gp_en_q[(reg_addr[1:0])*vit_pkg::GP_PORT_W +: vit_pkg::GP_PORT_W];
    end else begin
      // Unmapped addresses read as zero
      reg_rdata <= vit_pkg::BYTE_RESET;
    end
  end

endmodule
`default_nettype wire

// ---- pkg/vit_pkg.sv ----
// Constants shared by the interrupt controller, its checker and its bench.
// Assumes one 200 MHz clock and an 8-bit register port.
package vit_pkg;

  // ==========================================================
  // Clock and timer
  // ==========================================================
  localparam int unsigned CLK_PERIOD_PS = 5000;     // 200 MHz clock period
  localparam int unsigned TICK_PERIOD_NS = 1000;    // Timer advances once per microsecond
  localparam int unsigned TICK_CYCLES = (TICK_PERIOD_NS * 1000) / CLK_PERIOD_PS;
  localparam int unsigned TMR_W = 12;               // Free-running counter width
  localparam int unsigned TAP_FAST = 6;             // 128 us tap
  localparam int unsigned TAP_SLOW = 9;             // 1.024 ms tap
  localparam logic [TMR_W-1:0] TMR_RESET = 12'h000;

  // ==========================================================
  // Sources, in vector order (lowest index wins)
  // ==========================================================
  localparam int unsigned NUM_SRC = 11;
  localparam int unsigned VEC_W = 4;
  localparam int unsigned SRC_BUS_RESET = 0;
  localparam int unsigned SRC_TMR_FAST = 1;
  localparam int unsigned SRC_TMR_SLOW = 2;
  localparam int unsigned SRC_EP0 = 3;              // Five endpoints at 3..7
  localparam int unsigned NUM_EP = 5;
  localparam int unsigned SRC_SINK = 8;
  localparam int unsigned SRC_GPIO = 9;
  localparam int unsigned SRC_SERIAL = 10;

  // ==========================================================
  // Pins
  // ==========================================================
  localparam int unsigned SINK_W = 8;               // Current-sink port pins
  localparam int unsigned GP_PORTS = 4;             // General-purpose ports
  localparam int unsigned GP_PORT_W = 8;            // Pins per general-purpose port

  // ==========================================================
  // Register offsets (8-bit data)
  // ==========================================================
  localparam logic [7:0] REG_TMR_LO = 8'h00;        // Live low bits, read latches high bits
  localparam logic [7:0] REG_TMR_HI = 8'h01;        // Holding register
  localparam logic [7:0] REG_EN_LO = 8'h02;         // Source enable 7:0
  localparam logic [7:0] REG_EN_HI = 8'h03;         // Source enable 10:8
  localparam logic [7:0] REG_STAT_LO = 8'h04;       // Pending 7:0, read clears
  localparam logic [7:0] REG_STAT_HI = 8'h05;       // Pending 10:8, read clears
  localparam logic [7:0] REG_SINK_EN = 8'h06;       // Sink per-pin mask
  localparam logic [7:0] REG_SINK_POL = 8'h07;      // Sink per-pin polarity, 1 = rising
  localparam logic [7:0] REG_GP_EN0 = 8'h08;        // Port masks at 0x08..0x0b
  localparam logic [7:0] REG_GP_CFG = 8'h0c;        // Per-port polarity, 1 = rising

  // ==========================================================
  // Reset values
  // ==========================================================
  localparam logic [NUM_SRC-1:0] EN_RESET = 11'h000;
  localparam logic [NUM_SRC-1:0] PEND_RESET = 11'h000;
  localparam logic [7:0] BYTE_RESET = 8'h00;
  localparam logic [GP_PORTS-1:0] GP_CFG_RESET = 4'h0;
  localparam logic [VEC_W-1:0] VEC_RESET = 4'h0;

endpackage

// ---- hw/vit_pin_edge.sv ----
// Pin synchroniser and transition detector, one lane per pin.
// Assumes pins are asynchronous to clk; reset is already synchronised.
`timescale 1ns/1ps
`default_nettype none
module vit_pin_edge #(
  parameter int unsigned W = 8
) (
  input wire logic clk,
  input wire logic rst_sync_n,
  input wire logic [W-1:0] pin,
  output logic [W-1:0] rise,
  output logic [W-1:0] fall
);

  // ==========================================================
  // Per-pin lanes
  // ==========================================================
  genvar i;
  generate
    for (i = 0; i < W; i++) begin : g_lane
      logic s1_q;   // First stage, read only by s2_q
      logic s2_q;   // Second stage
      logic s3_q;   // Third stage
      logic val_q;  // Accepted level

      // Three-stage synchroniser
      always_ff @(posedge clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
          s1_q <= 1'b0;
          s2_q <= 1'b0;
          s3_q <= 1'b0;
        end else begin
          s1_q <= pin[i];
          s2_q <= s1_q;
          s3_q <= s2_q;
        end
      end

      // A change counts only once stages two and three agree
      always_ff @(posedge clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
          val_q <= 1'b0;
          rise[i] <= 1'b0;
          fall[i] <= 1'b0;
        end else begin
          rise[i] <= 1'b0;
          fall[i] <= 1'b0;
          if (s2_q == s3_q && s3_q != val_q) begin
            // One-cycle pulse on the accepted transition
            val_q <= s3_q;
            rise[i] <= s3_q;
            fall[i] <= ~s3_q;
          end
        end
      end
    end
  endgenerate

endmodule
`default_nettype wire

// ---- hw/placeholder_none.sv ----
`timescale 1ns/1ps

// ---- testbench/vit_cpu_model.sv ----
// Behavioural CPU core that takes the vector on irq and pulses int_ack.
// Assumes the controller clears the dispatched source on the ack edge.
`timescale 1ns/1ps
`default_nettype none
module vit_cpu_model (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic irq,
  input wire logic [3:0] irq_vec,
  input wire logic auto_ack,
  input wire logic slow,
  output logic int_ack,
  output logic [3:0] last_vec,
  output logic [7:0] ack_cnt
);
  // ==========================================================
  // Dispatch
  // ==========================================================
  logic [1:0] gap_q; // Cool-down, irq may linger one cycle with the old vector
  logic [2:0] dly_q; // Extra wait cycles in slow mode
  // One ack per irq assertion, then a pause before looking again
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      int_ack <= 1'b0;
      last_vec <= 4'h0;
      ack_cnt <= 8'h00;
      gap_q <= 2'h0;
      dly_q <= 3'h0;
    end else if (int_ack) begin
      int_ack <= 1'b0;
      gap_q <= 2'h3;
    end else if (gap_q != 2'h0) begin
      gap_q <= gap_q - 2'h1;
    end else if (auto_ack && irq && (!slow || dly_q == 3'h7)) begin
      int_ack <= 1'b1; // Dispatch clears the pending source
      last_vec <= irq_vec; // Own vector per source
      ack_cnt <= ack_cnt + 8'h01;
      dly_q <= 3'h0;
    end else if (auto_ack && irq) begin
      dly_q <= dly_q + 3'h1;
    end
  end
endmodule
`default_nettype wire

// ---- testbench/vit_top_checker.sv ----
// Port-level assertions for vit_top, attached by bind.
// Assumes register writes start only after the internal reset release.
`timescale 1ns/1ps
`default_nettype none
module vit_top_checker #(
  parameter int unsigned TICK_DIV = 2
) (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_rdata,
  input wire logic usb_bus_reset,
  input wire logic [4:0] ep_event,
  input wire logic serial_event,
  input wire logic [7:0] sink_pin,
  input wire logic [31:0] gp_pin,
  input wire logic int_ack,
  input wire logic irq,
  input wire logic [3:0] irq_vec
);
  // ==========================================================
  // Enable shadow, widened so any vector indexes it safely
  // ==========================================================
  logic [15:0] en_q;
  // Follows bus writes to the two enable bytes
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      en_q <= 16'h0000;
    end else if (reg_wr && reg_addr == vit_pkg::REG_EN_LO) begin
      en_q[7:0] <= reg_wdata;
    end else if (reg_wr && reg_addr == vit_pkg::REG_EN_HI) begin
      en_q[10:8] <= reg_wdata[2:0];
    end
  end
  // ==========================================================
  // Properties
  // ==========================================================
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!rst_n);
  property p_rd_idle;
    !reg_rd |=> reg_rdata == 8'h00;
  endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("read data not zero outside read");
  property p_unmapped;
    reg_rd && reg_addr > vit_pkg::REG_GP_CFG |=> reg_rdata == 8'h00;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
  property p_tmr_hi_rsvd;
    reg_rd && reg_addr == vit_pkg::REG_TMR_HI |=> reg_rdata[7:4] == 4'h0;
  endproperty
  a_tmr_hi_rsvd: assert property (p_tmr_hi_rsvd) else $error("timer high wider than 4");
  property p_tmr_step;
    (reg_rd && reg_addr == vit_pkg::REG_TMR_LO) ##2 (reg_rd && reg_addr == vit_pkg::REG_TMR_LO)
      |=> 8'(reg_rdata - $past(reg_rdata, 2)) <= 8'h01;
  endproperty
  a_tmr_step: assert property (p_tmr_step) else $error("timer jumped between reads");
  property p_vec_range;
    irq |-> irq_vec < vit_pkg::NUM_SRC;
  endproperty
  a_vec_range: assert property (p_vec_range) else $error("vector out of range");
  property p_irq_en;
    irq && $stable(en_q) |-> en_q[irq_vec];
  endproperty
  a_irq_en: assert property (p_irq_en) else $error("irq for disabled source");
  property p_bus_reset;
    usb_bus_reset && en_q[0] |-> ##2 (irq && irq_vec == 4'h0);
  endproperty
  a_bus_reset: assert property (p_bus_reset) else $error("bus reset not dispatched");
  property p_ack_clear;
    int_ack && irq |=> ##1 (!irq || irq_vec != $past(irq_vec, 2));
  endproperty
  a_ack_clear: assert property (p_ack_clear) else $error("acked source still pending");
  c_ack: cover property (int_ack && irq);
  c_gpio: cover property (irq && irq_vec == 4'h9);
  c_hold: cover property (reg_rd && reg_addr == vit_pkg::REG_TMR_HI);
endmodule
bind vit_top vit_top_checker #(.TICK_DIV(TICK_DIV)) vit_top_checker_i (
  .mclk(mclk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
  .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .usb_bus_reset(usb_bus_reset),
  .ep_event(ep_event), .serial_event(serial_event), .sink_pin(sink_pin), .gp_pin(gp_pin),
  .int_ack(int_ack), .irq(irq), .irq_vec(irq_vec)
);
`default_nettype wire

// ---- testbench/tb_vectored_interrupt_with_timer.sv ----
// Self-checking bench: vit_top with a CPU model on its dispatch side.
// Assumes a fast timer, TICK_DIV of 2, to keep tap periods short.
`timescale 1ns/1ps
`default_nettype none
module tb_vectored_interrupt_with_timer;
  // ==========================================================
  // Signals
  // ==========================================================
  logic mclk, rst_n, reg_wr, reg_rd, usb_bus_reset, serial_event, int_ack, irq, auto_ack, slow;
  logic [7:0] reg_addr, reg_wdata, reg_rdata, sink_pin, ack_cnt;
  logic [4:0] ep_event;
  logic [31:0] gp_pin;
  logic [3:0] irq_vec, last_vec;
  int err_total, compares;
  vit_top #(.TICK_DIV(2)) vit_top_i (.mclk(mclk), .rst_n(rst_n), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .usb_bus_reset(usb_bus_reset), .ep_event(ep_event), .serial_event(serial_event),
    .sink_pin(sink_pin), .gp_pin(gp_pin), .int_ack(int_ack), .irq(irq), .irq_vec(irq_vec));
  vit_cpu_model vit_cpu_model_i (.mclk(mclk), .rst_n(rst_n), .irq(irq), .irq_vec(irq_vec),
    .auto_ack(auto_ack), .slow(slow), .int_ack(int_ack), .last_vec(last_vec), .ack_cnt(ack_cnt));
  // 200 MHz clock
  always #2.5 mclk = ~mclk;
  // ==========================================================
  // Shared tasks
  // ==========================================================
  task automatic summarize();
    $display("Compares %0d mismatches %0d", compares, err_total);
    if (err_total == 0 && compares > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    compares++;
    if (got !== exp) begin
      $display("Error %s expected %h seen %h", what, exp, got);
      err_total++;
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge mclk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge mclk);
    reg_wr <= 1'b0;
  endtask
  // Data stand only in the cycle after the strobe, sampled 1 ns after its edge
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge mclk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge mclk);
    reg_rd <= 1'b0;
    #1;
    d = reg_rdata;
  endtask
  // Pin paths take six cycles, ten leaves margin
  task automatic look(input logic on, input logic [3:0] v);
    repeat (10) @(posedge mclk);
    #1;
    chk("irq", {7'h00, on}, {7'h00, irq});
    if (on) chk("irq_vec", {4'h0, v}, {4'h0, irq_vec});
  endtask
  // Bounded wait for the CPU model's next dispatch
  task automatic wait_ack(input int n, input logic [3:0] v);
    logic [7:0] c0;
    c0 = ack_cnt;
    for (int k = 0; k < n && ack_cnt === c0; k++) @(posedge mclk);
    if (ack_cnt === c0) begin
      $display("Error dispatch expected %h seen none", v);
      err_total++;
      summarize();
    end else begin
      chk("vector", {4'h0, v}, {4'h0, last_vec});
    end
  endtask
  task automatic pulse(input int s);
    @(posedge mclk);
    if (s == 0) usb_bus_reset <= 1'b1;
    else if (s == 10) serial_event <= 1'b1;
    else ep_event <= 5'(5'h01 << (s - 3));
    @(posedge mclk);
    usb_bus_reset <= 1'b0;
    ep_event <= 5'h00;
    serial_event <= 1'b0;
  endtask
  // ==========================================================
  // Scenarios
  // ==========================================================
  task automatic t_regs();
    logic [7:0] d;
    for (int a = 2; a <= 14; a++) begin
      rd(8'(a), d);
      chk("reset value", 8'h00, d);
    end
    wr(8'h40, 8'hff);
    rd(8'h40, d);
    chk("unmapped", 8'h00, d);
    wr(vit_pkg::REG_EN_HI, 8'hff);
    rd(vit_pkg::REG_EN_HI, d);
    chk("eleven enables", 8'h07, d);
    wr(vit_pkg::REG_EN_HI, 8'h00);
    $display("Test regs done");
  endtask
  task automatic t_timer();
    logic [7:0] lo, h1, h2, h3;
    rd(vit_pkg::REG_TMR_LO, lo);
    rd(vit_pkg::REG_TMR_HI, h1);
    repeat (600) @(posedge mclk);
    rd(vit_pkg::REG_TMR_HI, h2);
    chk("held high bits", h1, h2);
    rd(vit_pkg::REG_TMR_LO, lo);
    rd(vit_pkg::REG_TMR_LO, lo);
    rd(vit_pkg::REG_TMR_HI, h3);
    chk("high step", 8'h01, {7'h00, (h3 - h1 == 8'h01) || (h3 - h1 == 8'h02)});
    $display("Test timer done");
  endtask
  task automatic t_events();
    int srcs [7] = '{0, 3, 4, 5, 6, 7, 10};
    auto_ack <= 1'b1;
    wr(vit_pkg::REG_EN_LO, 8'hf9);
    wr(vit_pkg::REG_EN_HI, 8'h04);
    foreach (srcs[i]) begin
      pulse(srcs[i]);
      wait_ack(20, 4'(srcs[i]));
      look(1'b0, 4'h0);
    end
    auto_ack <= 1'b0;
    $display("Test events done");
  endtask
  task automatic t_pending();
    logic [7:0] d;
    @(posedge mclk);
    ep_event <= 5'h11;
    @(posedge mclk);
    ep_event <= 5'h00;
    look(1'b1, 4'h3);
    rd(vit_pkg::REG_STAT_LO, d);
    chk("pending", 8'h88, d);
    look(1'b0, 4'h0);
    wr(vit_pkg::REG_EN_LO, 8'h00);
    wr(vit_pkg::REG_EN_HI, 8'h00);
    pulse(4);
    look(1'b0, 4'h0);
    $display("Test pending done");
  endtask
  task automatic t_sink();
    logic [7:0] d;
    wr(vit_pkg::REG_EN_HI, 8'h01);
    wr(vit_pkg::REG_SINK_EN, 8'h05);
    wr(vit_pkg::REG_SINK_POL, 8'h01);
    @(posedge mclk);
    sink_pin <= 8'h02;
    look(1'b0, 4'h0);
    @(posedge mclk);
    sink_pin <= 8'h03;
    look(1'b1, 4'h8);
    rd(vit_pkg::REG_STAT_HI, d);
    chk("sink pending", 8'h01, d);
    @(posedge mclk);
    sink_pin <= 8'h07;
    look(1'b0, 4'h0);
    @(posedge mclk);
    sink_pin <= 8'h03;
    look(1'b1, 4'h8);
    rd(vit_pkg::REG_STAT_HI, d);
    $display("Test sink done");
  endtask
  task automatic t_gpio();
    logic [7:0] d;
    wr(vit_pkg::REG_EN_HI, 8'h02);
    wr(vit_pkg::REG_GP_CFG, 8'h02);
    wr(8'h09, 8'h80);
    wr(8'h0b, 8'h01);
    @(posedge mclk);
    gp_pin <= 32'h0001_8000;
    look(1'b1, 4'h9);
    rd(vit_pkg::REG_STAT_HI, d);
    chk("port pending", 8'h02, d);
    @(posedge mclk);
    gp_pin <= 32'h0100_8000;
    look(1'b0, 4'h0);
    @(posedge mclk);
    gp_pin <= 32'h0000_8000;
    look(1'b1, 4'h9);
    rd(vit_pkg::REG_STAT_HI, d);
    wr(vit_pkg::REG_EN_HI, 8'h00);
    $display("Test gpio done");
  endtask
  task automatic t_taps();
    logic [7:0] c0;
    auto_ack <= 1'b1;
    slow <= 1'b1;
    wr(vit_pkg::REG_EN_LO, 8'h02);
    wait_ack(300, 4'h1);
    wr(vit_pkg::REG_EN_LO, 8'h04);
    wait_ack(2200, 4'h2);
    wr(vit_pkg::REG_EN_LO, 8'h00);
    c0 = ack_cnt;
    repeat (600) @(posedge mclk);
    chk("taps off", c0, ack_cnt);
    $display("Test taps done");
  endtask
  // ==========================================================
  // Main sequence
  // ==========================================================
  initial begin
    {mclk, reg_wr, reg_rd, usb_bus_reset, serial_event, auto_ack, slow} = 7'h00;
    {reg_addr, reg_wdata, sink_pin, ep_event, gp_pin} = '0;
    rst_n = 1'b0;
    err_total = 0;
    compares = 0;
    repeat (5) @(posedge mclk);
    rst_n <= 1'b1;
    repeat (4) @(posedge mclk);
    t_regs();
    t_timer();
    t_events();
    t_pending();
    t_sink();
    t_gpio();
    t_taps();
    summarize();
  end
endmodule
`default_nettype wire
